//--- hw/epm_monitor.sv
`timescale 1ns/1ps
// Performance monitor counters and reporting latches
module epm_monitor
    import epm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Processor port
    input  wire logic       cpu_cs_n,
    input  wire logic       cpu_rd_n,
    input  wire logic [4:0] cpu_addr,
    output logic      [7:0] cpu_rdata,
    // Jitter attenuator FIFO
    input  wire logic [5:0] ja_fill,
    output logic            ja_read_slow,
    output logic            ja_read_fast,
    // Framer timing and sync
    input  wire logic       frame_tick,
    input  wire logic       basic_sync_lost,
    input  wire logic       fas_check,
    input  wire logic [2:0] fas_err_bits,
    // Error events
    input  wire logic       e_bit_err,
    input  wire logic       bpv_err,
    input  wire logic       pattern_err_wrap,
    input  wire logic       checksum_err_wrap,
    // Alarm conditions
    input  wire logic       rai_bit_high,
    input  wire logic       e_bits_low,
    input  wire logic       ais_det,
    input  wire logic       slot16_ais_det,
    input  wire logic       los_det,
    input  wire logic       aux_pattern_det,
    input  wire logic       multiframe_alarm_det,
    input  wire logic       slip_det
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_int_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Module state, except the reset synchronizer flops
    typedef struct packed {
        logic        rd_prev;  // Read strobe seen last cycle
        logic [7:0]  rdata;    // Read data register
        logic        near_q;   // FIFO was near a limit
        logic        slow;     // Read clock slowed
        logic        fast;     // Read clock sped up
        logic [7:0]  jfc;      // Jitter FIFO events
        logic [7:0]  ovf;      // Overflow latch
        logic [7:0]  lbf;      // Frames without sync
        logic        lost_q;   // Sync loss last cycle
        logic [7:0]  br;       // Alignment bit errors
        logic [7:0]  efas;     // Errored alignment words
        logic [7:0]  alarm;    // Alarm latch
        logic [15:0] bpv;      // Line violations
        logic [9:0]  ec;       // E-bit errors
    } epm_state_s;

    epm_state_s s_q;
    epm_state_s s_d;

    epm_rai_if rai_link ();

    logic       rd_go;        // One pulse per read access
    logic       near_under;   // Fill close to empty
    logic       near_over;    // Fill close to full
    logic       jfc_inc;      // Jitter event this cycle
    logic       lost_rise;    // Sync just lost
    logic       efas_inc;     // Errored word this cycle
    logic [7:0] ovf_set;      // Overflow events
    logic [7:0] alarm_set;    // Alarm events
    logic [8:0] br_sum;       // Alignment error sum with carry
    logic [7:0] rcrc_word;    // Status word image

    // Byte add with carry out
    function automatic logic [8:0] add8(input logic [7:0] v, input logic [7:0] a);
        add8 = {1'b0, v} + {1'b0, a};
    endfunction

    // Read data selection
    function automatic logic [7:0] read_mux(input logic [4:0] a, input epm_state_s s,
                                            input logic [7:0] rc);
        unique case (a)
            ADDR_EC_LOW:   read_mux = s.ec[7:0];
            ADDR_JFC:      read_mux = s.jfc;
            ADDR_OVF:      read_mux = s.ovf;
            ADDR_LBF:      read_mux = s.lbf;
            ADDR_BR:       read_mux = s.br;
            ADDR_RCRC:     read_mux = rc;
            ADDR_EFAS:     read_mux = s.efas;
            ADDR_ALARM:    read_mux = s.alarm;
            ADDR_BPV_HIGH: read_mux = s.bpv[15:8];
            default:       read_mux = RESET_BYTE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event decode
    always_comb begin
        // A held strobe counts once, so a slow read clears only once
        rd_go      = !cpu_cs_n && !cpu_rd_n && !s_q.rd_prev;
        // Four words of margin keeps the pointer off the real limit
        near_under = ja_fill <= JA_NEAR_WORDS;
        near_over  = ja_fill >= (JA_DEPTH - JA_NEAR_WORDS);
        jfc_inc    = (near_under || near_over) && !s_q.near_q;
        lost_rise  = basic_sync_lost && !s_q.lost_q;
        efas_inc   = fas_check && (fas_err_bits != 3'h0);
        br_sum     = add8(s_q.br, fas_check ? {5'h00, fas_err_bits} : 8'h00);
        rcrc_word  = {6'h00, rai_link.window_flag, rai_link.long_flag};
        // Overflow sources
        ovf_set = 8'h00;
        ovf_set[OVF_PATTERN] = pattern_err_wrap;
        ovf_set[OVF_FAR_END] = e_bit_err && (s_q.ec == 10'h3ff);
        ovf_set[OVF_JITTER]  = jfc_inc && (s_q.jfc == 8'hff);
        ovf_set[OVF_SYNC]    = frame_tick && basic_sync_lost && !lost_rise
                               && (s_q.lbf == 8'hff);
        ovf_set[OVF_ALIGN]   = br_sum[8];
        ovf_set[OVF_EFAS]    = efas_inc && (s_q.efas == 8'hff);
        ovf_set[OVF_VIOL]    = bpv_err && (s_q.bpv == 16'hffff);
        ovf_set[OVF_CHECK]   = checksum_err_wrap;
        // Alarm sources; bit 0 stays zero
        alarm_set = 8'h00;
        alarm_set[ALM_RAI]   = rai_bit_high;
        alarm_set[ALM_AIS]   = ais_det;
        alarm_set[ALM_SLOT16] = slot16_ais_det;
        alarm_set[ALM_LOS]    = los_det;
        alarm_set[ALM_AUX]    = aux_pattern_det;
        alarm_set[ALM_MULTI]  = multiframe_alarm_det;
        alarm_set[ALM_SLIP]  = slip_det;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d         = s_q;
        s_d.rd_prev = !cpu_cs_n && !cpu_rd_n;
        if (rd_go) begin
            s_d.rdata = read_mux(cpu_addr, s_q, rcrc_word);
        end
        // Jitter FIFO watch and read clock steering
        s_d.near_q = near_under || near_over;
        s_d.slow   = near_under;
        s_d.fast   = near_over;
        if (jfc_inc) begin
            s_d.jfc = s_q.jfc + 8'h01;
        end
        // Frames without basic sync; the transition clears first
        s_d.lost_q = basic_sync_lost;
        if (lost_rise) begin
            s_d.lbf = frame_tick ? 8'h01 : 8'h00;
        end else if (frame_tick && basic_sync_lost) begin
            s_d.lbf = s_q.lbf + 8'h01;
        end
        // Alignment errors, bit total and word count
        s_d.br = br_sum[7:0];
        if (efas_inc) begin
            s_d.efas = s_q.efas + 8'h01;
        end
        // Line violations and far end errors
        if (bpv_err) begin
            s_d.bpv = s_q.bpv + 16'h0001;
        end
        if (e_bit_err) begin
            s_d.ec = s_q.ec + 10'h001;
        end
        // Latches: a new event in the read cycle survives the clear
        s_d.ovf = s_q.ovf;
        if (rd_go && cpu_addr == ADDR_OVF) begin
            s_d.ovf = 8'h00;
        end
        s_d.ovf = s_d.ovf | ovf_set;
        s_d.alarm = s_q.alarm;
        if (rd_go && cpu_addr == ADDR_ALARM) begin
            s_d.alarm = 8'h00;
        end
        s_d.alarm = s_d.alarm | alarm_set;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Persistence timer for remote alarm with CRC errors
    assign rai_link.frame_tick = frame_tick;
    assign rai_link.cond       = rai_bit_high && e_bits_low;
    assign rai_link.clr        = rd_go && (cpu_addr == ADDR_RCRC);

    epm_rai_timer u_timer (
        .clk_sys   (clk_sys),
        .rst_int_n (rst_int_n),
        .rai       (rai_link.tmr)
    );

    // Outputs straight from flops
    assign cpu_rdata    = s_q.rdata;
    assign ja_read_slow = s_q.slow;
    assign ja_read_fast = s_q.fast;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_int_n);

    sequence s_near_entry;
        // Entry: near now, and the registered copy says not near before
        !s_q.near_q && (near_under || near_over);
    endsequence

    jitter_count_a: assert property (
        s_near_entry |=> s_q.jfc == 8'($past(s_q.jfc) + 8'h01))
        else $error("jitter counter missed a near-limit entry");
    clock_steer_a: assert property (
        near_under |=> ja_read_slow && !ja_read_fast)
        else $error("read clock not slowed near underflow");
    jitter_wrap_a: assert property (
        jfc_inc && s_q.jfc == 8'hff |=> s_q.ovf[OVF_JITTER] && s_q.jfc == 8'h00)
        else $error("jitter wrap not latched");
    ovf_clear_a: assert property (
        rd_go && cpu_addr == ADDR_OVF |=> s_q.ovf == $past(ovf_set))
        else $error("overflow latch not cleared by read");
    sync_clear_a: assert property (
        lost_rise && !frame_tick |=> s_q.lbf == 8'h00)
        else $error("sync loss counter not cleared");
    sync_count_a: assert property (
        frame_tick && basic_sync_lost && !lost_rise
        |=> s_q.lbf == 8'($past(s_q.lbf) + 8'h01))
        else $error("frame without sync not counted");
    align_sum_a: assert property (
        fas_check |=> s_q.br == 8'($past(s_q.br) + {5'h00, $past(fas_err_bits)}))
        else $error("alignment bit errors not accumulated");
    efas_count_a: assert property (
        fas_check && fas_err_bits == 3'h0 |=> s_q.efas == $past(s_q.efas))
        else $error("clean alignment word counted");
    alarm_hold_a: assert property (
        ais_det ##1 !(rd_go && cpu_addr == ADDR_ALARM) |=> s_q.alarm[ALM_AIS])
        else $error("all-ones alarm not held until read");
    viol_count_a: assert property (
        bpv_err |=> s_q.bpv == 16'($past(s_q.bpv) + 16'h0001))
        else $error("line violation not counted");
endmodule

//--- hw/epm_pkg.sv
// What this block does
// - Jitter counter counts entries within four words.
// - Near a limit, slow or speed read clock.
// - Pattern counter wrap sets latch bit 7.
// - E-bit counter wrap sets latch bit 6.
// - Jitter counter wrap sets latch bit 5.
// - Sync loss counter wrap sets bit 4.
// - Alignment error counter wrap sets bit 3.
// - Errored alignment counter wrap sets bit 2.
// - Violation counter wrap sets latch bit 1.
// - Checksum counter wrap sets latch bit 0.
// - Count frame periods spent without basic sync.
// - Sync loss counter clears on losing sync.
// - Accumulate bit errors in alignment signal.
// - Window flag: condition lasted 10 to 450 ms.
// - Long flag: condition held over 10 ms.
// - Count alignment words holding any error.
// - Alarm latch bit 7 on remote alarm.
// - Bits 6,5 on all-ones and slot-16 all-ones.
// - Alarm latch bit 4 on signal loss.
// - Bits 3,2 on auxiliary and multiframe alarms.
// - Bit 1 on buffer slip; bit 0 unused.
// - 16-bit violation counter, high byte readable.
// - E-bit counter low byte at lower address.
package epm_pkg;
    // Register offsets on the processor port
    localparam logic [4:0] ADDR_EC_LOW   = 5'h14;
    localparam logic [4:0] ADDR_JFC      = 5'h15;
    localparam logic [4:0] ADDR_OVF      = 5'h16;
    localparam logic [4:0] ADDR_LBF      = 5'h17;
    localparam logic [4:0] ADDR_BR       = 5'h18;
    localparam logic [4:0] ADDR_RCRC     = 5'h19;
    localparam logic [4:0] ADDR_EFAS     = 5'h1a;
    localparam logic [4:0] ADDR_ALARM    = 5'h1b;
    localparam logic [4:0] ADDR_BPV_HIGH = 5'h1c;
    // Overflow latch bit positions
    localparam int OVF_PATTERN = 7;
    localparam int OVF_FAR_END = 6;
    localparam int OVF_JITTER  = 5;
    localparam int OVF_SYNC    = 4;
    localparam int OVF_ALIGN   = 3;
    localparam int OVF_EFAS    = 2;
    localparam int OVF_VIOL    = 1;
    localparam int OVF_CHECK   = 0;
    // Alarm latch bit positions
    localparam int ALM_RAI   = 7;
    localparam int ALM_AIS   = 6;
    localparam int ALM_SLOT16 = 5;
    localparam int ALM_LOS    = 4;
    localparam int ALM_AUX    = 3;
    localparam int ALM_MULTI  = 2;
    localparam int ALM_SLIP  = 1;
    // Jitter attenuator FIFO geometry
    localparam logic [5:0] JA_DEPTH      = 6'h20;
    localparam logic [5:0] JA_NEAR_WORDS = 6'h04;
    // Frame period and alarm persistence times
    localparam int FRAME_US  = 125;
    localparam int LONG_MS   = 10;
    localparam int WINDOW_MS = 450;
    localparam logic [11:0] LONG_FRAMES   = 12'(LONG_MS * 1000 / FRAME_US);
    localparam logic [11:0] WINDOW_FRAMES = 12'(WINDOW_MS * 1000 / FRAME_US);
    // Value of every register after reset
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

//--- hw/epm_rai_if.sv
`timescale 1ns/1ps
// Carrier between the monitor and the persistence timer
interface epm_rai_if;
    logic frame_tick;   // One pulse per 125 us frame
    logic cond;         // A bits high and E bits low
    logic clr;          // Read of the status word
    logic long_flag;    // Condition held over the long time
    logic window_flag;  // Sticky window flag
    modport mon (output frame_tick, output cond, output clr,
                 input long_flag, input window_flag);
    modport tmr (input frame_tick, input cond, input clr,
                 output long_flag, output window_flag);
endinterface

//--- hw/epm_rai_timer.sv
`timescale 1ns/1ps
// Measures how long remote alarm with continuous CRC errors lasts
module epm_rai_timer
    import epm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_int_n,
    // Link to the monitor
    epm_rai_if.tmr   rai
);
    typedef struct packed {
        logic [11:0] frames;  // Frames the condition has held
        logic        long_f;  // Level flag
        logic        win_f;   // Sticky flag
    } epm_tmr_s;

    epm_tmr_s s_q;
    epm_tmr_s s_d;
    logic     ended_in_window;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        // Episode ends inside the window when the condition drops
        ended_in_window = !rai.cond && (s_q.frames > LONG_FRAMES)
                          && (s_q.frames < WINDOW_FRAMES);
        if (!rai.cond) begin
            s_d.frames = 12'h000;
        end else if (rai.frame_tick && s_q.frames != WINDOW_FRAMES) begin
            // Saturate: beyond the window only the long flag matters
            s_d.frames = s_q.frames + 12'h001;
        end
        s_d.long_f = rai.cond && (s_d.frames > LONG_FRAMES);
        // Set wins over a read in the same cycle
        s_d.win_f = (s_q.win_f && !rai.clr) || ended_in_window;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rai.long_flag   = s_q.long_f;
    assign rai.window_flag = s_q.win_f;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_int_n);

    long_flag_level_a: assert property (
        rai.cond && s_q.frames > LONG_FRAMES |=> rai.cond |-> rai.long_flag)
        else $error("long flag missing after long condition");
    window_set_a: assert property (
        ended_in_window |=> rai.window_flag)
        else $error("window flag not set at episode end");
    window_hold_a: assert property (
        !ended_in_window && !rai.clr && rai.window_flag |=> rai.window_flag)
        else $error("window flag dropped without read");
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
    import epm_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and reset
    logic        clk_sys;         // 125 MHz system clock
    logic        rst_n;           // Active-low reset
    // Processor port
    logic        cpu_cs_n;        // Chip select, active low
    logic        cpu_rd_n;        // Read strobe, active low
    logic [4:0]  cpu_addr;        // Register address
    logic [7:0]  cpu_rdata;       // Registered read data
    // Jitter FIFO
    logic [5:0]  ja_fill;         // Fill level seen by the monitor
    logic        ja_read_slow;    // Read clock slow-down request
    logic        ja_read_fast;    // Read clock speed-up request
    // Levels
    logic        basic_sync_lost; // High while sync is lost
    logic [2:0]  fas_err_bits;    // Errored bits in a checked word
    logic        rai_bit_high;    // Remote alarm bit level
    logic        e_bits_low;      // E bits low level
    // Pulsed events, one bit each
    logic [11:0] ev;
    int          err_count;       // Mismatches seen
    int          checks;          // Comparisons made
    ////////////////////////////////////////////////////////////////////////////////
    epm_monitor u_epm_monitor (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
        .ja_fill(ja_fill), .ja_read_slow(ja_read_slow), .ja_read_fast(ja_read_fast),
        .frame_tick(ev[10]), .basic_sync_lost(basic_sync_lost), .fas_check(ev[11]),
        .fas_err_bits(fas_err_bits), .e_bit_err(ev[0]), .bpv_err(ev[1]),
        .pattern_err_wrap(ev[2]), .checksum_err_wrap(ev[3]),
        .rai_bit_high(rai_bit_high), .e_bits_low(e_bits_low), .ais_det(ev[4]),
        .slot16_ais_det(ev[5]), .los_det(ev[6]), .aux_pattern_det(ev[7]),
        .multiframe_alarm_det(ev[8]),
        .slip_det(ev[9])
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock, 8 ns period
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Compare one byte, report and count
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    // One register read; strobe released only after data is taken
    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cpu_cs_n = 1'b0;
        cpu_rd_n = 1'b0;
        cpu_addr = a;
        @(negedge clk_sys);
        @(negedge clk_sys);
        check($sformatf("reg %h", a), exp, cpu_rdata);
        cpu_cs_n = 1'b1;
        cpu_rd_n = 1'b1;
        @(negedge clk_sys);
    endtask
    // Single-cycle pulses with a gap, so every pulse counts once
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            ev[idx] = 1'b1;
            @(negedge clk_sys);
            ev[idx] = 1'b0;
        end
    endtask
    // Verdict, one place only
    task automatic test_done();
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Everything reads zero after reset, holes included
    task automatic t_reset();
        for (int a = 'h13; a <= 'h1d; a++) begin
            rdchk(5'(a), 8'h00);
        end
        check("slow", 8'h00, {7'h00, ja_read_slow});
    endtask
    // Near-zone entries count once each; pacing follows the zone
    task automatic t_jitter();
        for (int i = 0; i < 256; i++) begin
            @(negedge clk_sys);
            ja_fill = (i % 2 == 0) ? 6'h02 : 6'h1e;
            @(negedge clk_sys);
            if (i == 0) begin
                check("slow", 8'h01, {7'h00, ja_read_slow});
                repeat (3) @(negedge clk_sys);
                rdchk(ADDR_JFC, 8'h01);
            end
            if (i == 1) check("fast", 8'h01, {7'h00, ja_read_fast});
            ja_fill = 6'h10;
        end
        rdchk(ADDR_JFC, 8'h00);
        rdchk(ADDR_OVF, 8'h01 << OVF_JITTER);
        rdchk(ADDR_OVF, 8'h00);
    endtask
    // Error-bit sums and errored-word counts, both wrapping
    task automatic t_alignment();
        fas_err_bits = 3'h3;
        pulse(11, 1);
        fas_err_bits = 3'h0;
        pulse(11, 1);
        rdchk(ADDR_BR, 8'h03);
        rdchk(ADDR_EFAS, 8'h01);
        fas_err_bits = 3'h1;
        pulse(11, 253);
        rdchk(ADDR_BR, 8'h00);
        rdchk(ADDR_OVF, 8'h01 << OVF_ALIGN);
        pulse(11, 2);
        rdchk(ADDR_EFAS, 8'h00);
        rdchk(ADDR_OVF, 8'h01 << OVF_EFAS);
    endtask
    // Frame periods while lost; clear on a new loss; wrap
    task automatic t_sync();
        @(negedge clk_sys);
        basic_sync_lost = 1'b1;
        pulse(10, 5);
        rdchk(ADDR_LBF, 8'h05);
        basic_sync_lost = 1'b0;
        pulse(10, 2);
        rdchk(ADDR_LBF, 8'h05);
        basic_sync_lost = 1'b1;
        repeat (2) @(negedge clk_sys);
        rdchk(ADDR_LBF, 8'h00);
        pulse(10, 256);
        rdchk(ADDR_LBF, 8'h00);
        rdchk(ADDR_OVF, 8'h01 << OVF_SYNC);
        basic_sync_lost = 1'b0;
    endtask
    // E-bit and violation counters, external wraps
    task automatic t_counts();
        pulse(0, 3);
        rdchk(ADDR_EC_LOW, 8'h03);
        pulse(0, 1021);
        rdchk(ADDR_EC_LOW, 8'h00);
        rdchk(ADDR_OVF, 8'h01 << OVF_FAR_END);
        pulse(1, 256);
        rdchk(ADDR_BPV_HIGH, 8'h01);
        // Held event counts every cycle: 65280 more reach the wrap
        @(negedge clk_sys);
        ev[1] = 1'b1;
        repeat (65280) @(negedge clk_sys);
        ev[1] = 1'b0;
        rdchk(ADDR_BPV_HIGH, 8'h00);
        rdchk(ADDR_OVF, 8'h01 << OVF_VIOL);
        pulse(2, 1);
        rdchk(ADDR_OVF, 8'h01 << OVF_PATTERN);
        pulse(3, 1);
        rdchk(ADDR_OVF, 8'h01 << OVF_CHECK);
        rdchk(ADDR_OVF, 8'h00);
    endtask
    // Each pulsed alarm source sets its own bit; a read clears it
    task automatic t_alarms();
        int pos [6];
        pos = '{ALM_AIS, ALM_SLOT16, ALM_LOS, ALM_AUX, ALM_MULTI, ALM_SLIP};
        for (int i = 0; i < 6; i++) begin
            pulse(4 + i, 1);
            rdchk(ADDR_ALARM, 8'h01 << pos[i]);
            rdchk(ADDR_ALARM, 8'h00);
        end
    endtask
    // Alarm with continuous CRC errors: long level, then window flag
    task automatic t_rai();
        @(negedge clk_sys);
        rai_bit_high = 1'b1;
        e_bits_low = 1'b1;
        pulse(10, 60);
        rdchk(ADDR_RCRC, 8'h00);
        pulse(10, 40);
        rdchk(ADDR_RCRC, 8'h01);
        rai_bit_high = 1'b0;
        e_bits_low = 1'b0;
        pulse(10, 1);
        rdchk(ADDR_RCRC, 8'h02);
        rdchk(ADDR_RCRC, 8'h00);
        rdchk(ADDR_ALARM, 8'h01 << ALM_RAI);
        rdchk(ADDR_ALARM, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: inputs quiet, reset for 8 cycles, then scenarios
    initial begin
        err_count = 0;
        checks = 0;
        rst_n = 1'b0;
        cpu_cs_n = 1'b1;
        cpu_rd_n = 1'b1;
        cpu_addr = 5'h00;
        ja_fill = 6'h10;
        basic_sync_lost = 1'b0;
        fas_err_bits = 3'h0;
        rai_bit_high = 1'b0;
        e_bits_low = 1'b0;
        ev = 12'h000;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_reset();
        t_jitter();
        t_alignment();
        t_sync();
        t_counts();
        t_alarms();
        t_rai();
        test_done();
    end
    // Hang guard, beyond the roughly 70000 cycles needed
    initial begin
        #(90000 * 8);
        err_count++;
        test_done();
    end
endmodule
